// [risl_defines.vh]
// Register indexes, field positions and reset values of the interrupt status latch
`ifndef RISL_DEFINES_VH
`define RISL_DEFINES_VH

// Register indexes; byte address is four times the index
`define RISL_IDX_OPT        8'h40
`define RISL_IDX_EDGE       8'h41
`define RISL_IDX_SYNC_ST    8'h43
`define RISL_IDX_SYNC_MASK  8'h44
`define RISL_IDX_SYNC_CLR   8'h45
`define RISL_IDX_FORCE_ST   8'h48
`define RISL_IDX_FORCE_MASK 8'h49
`define RISL_IDX_FORCE_CLR  8'h4a
`define RISL_IDX_FORCE_SET  8'h4b
`define RISL_IDX_CH1_ST     8'h5c
`define RISL_IDX_CH1_MASK   8'h5d
`define RISL_IDX_CH1_CLR    8'h5e
`define RISL_IDX_LINK_ST    8'h90
`define RISL_IDX_LINK_MASK  8'h91
`define RISL_IDX_LINK_CLR   8'h92
`define RISL_IDX_RAW        8'h93
`define RISL_IDX_LINK_RAW   8'h94

// Field positions
`define RISL_BIT_KEEP       4
`define RISL_BIT_TV_EDGE    4
`define RISL_BIT_LOCK_EDGE  5
`define RISL_BIT_TV         4
`define RISL_BIT_UNLOCK     3
`define RISL_BIT_LOCK       2
`define RISL_BIT_FORCE      7
`define RISL_BIT_CH1_LOCK   3
`define RISL_BIT_CH1_UNLOCK 2
`define RISL_BIT_CH1_TV     1

// Implemented bits of each group
`define RISL_SYNC_BITS      8'h1c
`define RISL_FORCE_BITS     8'h80
`define RISL_CH1_BITS       8'h0e
`define RISL_OPT_BITS       8'h10
`define RISL_EDGE_BITS      8'h30

// Reset values
`define RISL_RST_OPT        8'h00
`define RISL_RST_EDGE       8'h30
`define RISL_RST_MASK       8'h00
`define RISL_RST_FLAG       1'b0

`endif

// [risl_flag_cell.v]
// One sticky interrupt status flag with set-over-clear priority
`timescale 1ns/1ps
`default_nettype none
`include "risl_defines.vh"

module risl_flag_cell (
  input  wire sys_clk,
  input  wire sys_rst,
  input  wire event_in,
  input  wire allow,
  input  wire clear,
  output reg  flag_reg
);

  reg flag_next;

  always @* begin
    flag_next = flag_reg;
    if (clear) begin
      flag_next = 1'b0;
    end
    // A new event in the clear cycle still lands
    if (event_in && allow) begin
      flag_next = 1'b1;
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      flag_reg <= `RISL_RST_FLAG;
    end else begin
      flag_reg <= flag_next;
    end
  end

endmodule // risl_flag_cell

`default_nettype wire

// [risl_top.v]
// Interrupt status latch with AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "risl_defines.vh"

module risl_top (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        timing_valid_raw,
  input  wire        proc_lock_raw,
  input  wire        ch1_timing_valid_raw,
  input  wire        ch1_lock_raw,
  input  wire [7:0]  link_event_raw,
  output reg         first_irq_output
);

  // Register index match, used by every strobe decode
  function sel;
    input [7:0] idx;
    input [7:0] target;
    begin
      sel = (idx == target);
    end
  endfunction

  // Raw inputs come from other domains: two-stage synchroniser
  reg  [11:0] raw_s1_reg;
  reg  [11:0] raw_s2_reg;
  reg  [11:0] raw_prev_reg;
  wire [11:0] raw_in;
  wire [11:0] rise;
  wire [11:0] fall;

  assign raw_in = {link_event_raw, ch1_lock_raw, ch1_timing_valid_raw,
                   proc_lock_raw, timing_valid_raw};

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      raw_s1_reg   <= 12'h000;
      raw_s2_reg   <= 12'h000;
      raw_prev_reg <= 12'h000;
    end else begin
      raw_s1_reg   <= raw_in;
      raw_s2_reg   <= raw_s1_reg;
      raw_prev_reg <= raw_s2_reg;
    end
  end

  // History holds pin samples only three edges after release; before that
  // a pin already high would fake an edge. Real changes then are lost.
  reg [2:0] hist_ok_reg;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      hist_ok_reg <= 3'b000;
    end else begin
      hist_ok_reg <= {hist_ok_reg[1:0], 1'b1};
    end
  end

  assign rise = raw_s2_reg & ~raw_prev_reg & {12{hist_ok_reg[2]}};
  assign fall = ~raw_s2_reg & raw_prev_reg & {12{hist_ok_reg[2]}};

  // Control registers
  reg [7:0] opt_reg;
  reg [7:0] edge_reg;
  reg [7:0] sync_mask_reg;
  reg [7:0] force_mask_reg;
  reg [7:0] ch1_mask_reg;
  reg [7:0] link_mask_reg;

  wire keep_flags_when_masked;
  wire timing_valid_edge_choice;
  wire lock_edge_choice;

  assign keep_flags_when_masked   = opt_reg[`RISL_BIT_KEEP];
  assign timing_valid_edge_choice = edge_reg[`RISL_BIT_TV_EDGE];
  assign lock_edge_choice         = edge_reg[`RISL_BIT_LOCK_EDGE];

  // AHB-Lite data phase state
  reg        dp_valid_reg;
  reg        dp_write_reg;
  reg [7:0]  dp_idx_reg;
  wire       acc;
  wire       addr_ok;
  wire [7:0] acc_idx;
  wire       wr;

  // Only word-aligned addresses inside the low 1 KB are mapped; a size
  // wider than the 32-bit bus is illegal and lands nowhere
  assign addr_ok = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'b00) &&
                   (hsize <= 3'b010);
  assign acc     = hsel && htrans[1] && hready;
  assign acc_idx = addr_ok ? haddr[9:2] : 8'hff;
  assign wr      = dp_valid_reg && dp_write_reg;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_idx_reg   <= 8'h00;
    end else begin
      dp_valid_reg <= acc;
      if (acc) begin
        dp_write_reg <= hwrite;
        dp_idx_reg   <= acc_idx;
      end
    end
  end

  // Write decode in the data phase
  wire wr_opt;
  wire wr_edge;
  wire wr_sync_mask;
  wire wr_force_mask;
  wire wr_ch1_mask;
  wire wr_link_mask;
  wire wr_force_set;
  wire [7:0] sync_clr;
  wire [7:0] force_clr;
  wire [7:0] ch1_clr;
  wire [7:0] link_clr;

  assign wr_opt        = wr && sel(dp_idx_reg, `RISL_IDX_OPT);
  assign wr_edge       = wr && sel(dp_idx_reg, `RISL_IDX_EDGE);
  assign wr_sync_mask  = wr && sel(dp_idx_reg, `RISL_IDX_SYNC_MASK);
  assign wr_force_mask = wr && sel(dp_idx_reg, `RISL_IDX_FORCE_MASK);
  assign wr_ch1_mask   = wr && sel(dp_idx_reg, `RISL_IDX_CH1_MASK);
  assign wr_link_mask  = wr && sel(dp_idx_reg, `RISL_IDX_LINK_MASK);
  assign wr_force_set  = wr && sel(dp_idx_reg, `RISL_IDX_FORCE_SET);

  // Write one to clear; zeros leave flags alone
  assign sync_clr  = (wr && sel(dp_idx_reg, `RISL_IDX_SYNC_CLR)) ?
                     hwdata[7:0] : 8'h00;
  assign force_clr = (wr && sel(dp_idx_reg, `RISL_IDX_FORCE_CLR)) ?
                     hwdata[7:0] : 8'h00;
  assign ch1_clr   = (wr && sel(dp_idx_reg, `RISL_IDX_CH1_CLR)) ?
                     hwdata[7:0] : 8'h00;
  assign link_clr  = (wr && sel(dp_idx_reg, `RISL_IDX_LINK_CLR)) ?
                     hwdata[7:0] : 8'h00;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      opt_reg        <= `RISL_RST_OPT;
      edge_reg       <= `RISL_RST_EDGE;
      sync_mask_reg  <= `RISL_RST_MASK;
      force_mask_reg <= `RISL_RST_MASK;
      ch1_mask_reg   <= `RISL_RST_MASK;
      link_mask_reg  <= `RISL_RST_MASK;
    end else begin
      if (wr_opt) begin
        opt_reg <= hwdata[7:0] & `RISL_OPT_BITS;
      end
      if (wr_edge) begin
        edge_reg <= hwdata[7:0] & `RISL_EDGE_BITS;
      end
      if (wr_sync_mask) begin
        sync_mask_reg <= hwdata[7:0] & `RISL_SYNC_BITS;
      end
      if (wr_force_mask) begin
        force_mask_reg <= hwdata[7:0] & `RISL_FORCE_BITS;
      end
      if (wr_ch1_mask) begin
        ch1_mask_reg <= hwdata[7:0] & `RISL_CH1_BITS;
      end
      if (wr_link_mask) begin
        link_mask_reg <= hwdata[7:0];
      end
    end
  end

  // Event detection
  reg [7:0] sync_ev;
  reg [7:0] force_ev;
  reg [7:0] ch1_ev;

  always @* begin
    sync_ev  = 8'h00;
    force_ev = 8'h00;
    ch1_ev   = 8'h00;
    sync_ev[`RISL_BIT_TV]     = rise[0] | (timing_valid_edge_choice & fall[0]);
    sync_ev[`RISL_BIT_LOCK]   = rise[1] | (lock_edge_choice & fall[1]);
    sync_ev[`RISL_BIT_UNLOCK] = fall[1] | (lock_edge_choice & rise[1]);
    force_ev[`RISL_BIT_FORCE] = wr_force_set & hwdata[`RISL_BIT_FORCE];
    ch1_ev[`RISL_BIT_CH1_LOCK]   = rise[3];
    ch1_ev[`RISL_BIT_CH1_UNLOCK] = fall[3];
    ch1_ev[`RISL_BIT_CH1_TV]  = rise[2] | (timing_valid_edge_choice & fall[2]);
  end

  // All four groups side by side: sync, forced, channel 1, link
  wire [31:0] ev_vec;
  wire [31:0] mask_vec;
  wire [31:0] allow_vec;
  wire [31:0] clr_vec;
  wire [31:0] flag_vec;

  assign ev_vec    = {rise[11:4], ch1_ev, force_ev, sync_ev};
  assign mask_vec  = {link_mask_reg, ch1_mask_reg, force_mask_reg, sync_mask_reg};
  // Keep option widens only the link group
  assign allow_vec = {link_mask_reg | {8{keep_flags_when_masked}},
                      ch1_mask_reg, force_mask_reg, sync_mask_reg};
  assign clr_vec   = {link_clr, ch1_clr, force_clr, sync_clr};

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_flag
      risl_flag_cell u_flag (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .event_in (ev_vec[gi]),
        .allow    (allow_vec[gi]),
        .clear    (clr_vec[gi]),
        .flag_reg (flag_vec[gi])
      );
    end
  endgenerate

  wire [7:0] sync_lock_status;
  wire [7:0] forced_interrupt_status;
  wire [7:0] channel1_sync_status;
  wire [7:0] link_status;

  assign sync_lock_status        = flag_vec[7:0] & `RISL_SYNC_BITS;
  assign forced_interrupt_status = flag_vec[15:8] & `RISL_FORCE_BITS;
  assign channel1_sync_status    = flag_vec[23:16] & `RISL_CH1_BITS;
  assign link_status             = flag_vec[31:24];

  // Read mux; raw levels let firmware judge link validity groups
  reg [31:0] rd_data;

  always @* begin
    rd_data = 32'h00000000;
    case (acc_idx)
      `RISL_IDX_OPT:        rd_data[7:0] = opt_reg;
      `RISL_IDX_EDGE:       rd_data[7:0] = edge_reg;
      `RISL_IDX_SYNC_ST:    rd_data[7:0] = sync_lock_status;
      `RISL_IDX_SYNC_MASK:  rd_data[7:0] = sync_mask_reg;
      `RISL_IDX_FORCE_ST:   rd_data[7:0] = forced_interrupt_status;
      `RISL_IDX_FORCE_MASK: rd_data[7:0] = force_mask_reg;
      `RISL_IDX_CH1_ST:     rd_data[7:0] = channel1_sync_status;
      `RISL_IDX_CH1_MASK:   rd_data[7:0] = ch1_mask_reg;
      `RISL_IDX_LINK_ST:    rd_data[7:0] = link_status;
      `RISL_IDX_LINK_MASK:  rd_data[7:0] = link_mask_reg;
      `RISL_IDX_RAW:        rd_data[7:0] = {4'h0, raw_s2_reg[3:0]};
      `RISL_IDX_LINK_RAW:   rd_data[7:0] = raw_s2_reg[11:4];
      default:              rd_data = 32'h00000000;
    endcase
  end

  // Zero-wait slave; read data registered at the address phase edge
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (acc && !hwrite) begin
        hrdata <= rd_data;
      end else begin
        hrdata <= 32'h00000000;
      end
    end
  end

  // Kept-but-masked flags are visible yet stay off the pin
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      first_irq_output <= 1'b0;
    end else begin
      first_irq_output <= |(flag_vec & mask_vec);
    end
  end

endmodule // risl_top

`default_nettype wire

// [risl_props.sv]
// Assertion checker for the interrupt status latch, bound to its top module
`timescale 1ns/1ps
`default_nettype none
`include "risl_defines.vh"
module risl_props (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        timing_valid_raw,
  input wire logic        proc_lock_raw,
  input wire logic        ch1_timing_valid_raw,
  input wire logic        ch1_lock_raw,
  input wire logic [7:0]  link_event_raw,
  input wire logic        first_irq_output
);
  logic       take;
  logic       wr_reg;
  logic       rd_reg;
  logic       fmask_reg;
  logic [7:0] idx_reg;
  assign take = hsel & htrans[1] & hready;
  // Track the data phase and the forced-event mask from the bus alone
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_reg    <= 1'b0;
      rd_reg    <= 1'b0;
      fmask_reg <= 1'b0;
    end else begin
      wr_reg <= take & hwrite;
      rd_reg <= take & ~hwrite;
      if (wr_reg && idx_reg == `RISL_IDX_FORCE_MASK)
        fmask_reg <= hwdata[7];
    end
    if (take)
      idx_reg <= haddr[9:2];
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence rd_of(logic [7:0] i);
    rd_reg && idx_reg == i;
  endsequence
  sequence force_hit;
    wr_reg && idx_reg == `RISL_IDX_FORCE_SET && hwdata[7] && fmask_reg;
  endsequence
  property only_bits(logic [7:0] i, logic [7:0] m);
    rd_of(i) |-> (hrdata & ~{24'h0, m}) == 32'h0;
  endproperty
  a_reset_quiet: assert property ($fell(sys_rst) |-> !first_irq_output && hrdata == 32'h0)
    else $error("outputs not quiet after reset");
  a_irq_sticky: assert property ($fell(first_irq_output) |-> $past(wr_reg, 2))
    else $error("irq dropped without a write");
  a_force_irq: assert property (force_hit |-> ##2 first_irq_output)
    else $error("forced event gave no irq");
  a_sync_bits: assert property (only_bits(`RISL_IDX_SYNC_ST, `RISL_SYNC_BITS))
    else $error("stray bits in sync status");
  a_force_bits: assert property (only_bits(`RISL_IDX_FORCE_ST, `RISL_FORCE_BITS))
    else $error("stray bits in forced status");
  a_ch1_bits: assert property (only_bits(`RISL_IDX_CH1_ST, `RISL_CH1_BITS))
    else $error("stray bits in channel 1 status");
  a_opt_bits: assert property (only_bits(`RISL_IDX_OPT, `RISL_OPT_BITS))
    else $error("stray bits in option register");
  a_edge_bits: assert property (only_bits(`RISL_IDX_EDGE, `RISL_EDGE_BITS))
    else $error("stray bits in edge register");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("slave left zero-wait OKAY");
endmodule // risl_props
bind risl_top risl_props i_props (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .timing_valid_raw(timing_valid_raw), .proc_lock_raw(proc_lock_raw),
  .ch1_timing_valid_raw(ch1_timing_valid_raw), .ch1_lock_raw(ch1_lock_raw),
  .link_event_raw(link_event_raw), .first_irq_output(first_irq_output));
`default_nettype wire

// [risl_host.sv]
// Host firmware model: AHB-Lite master and link interrupt validity checks
`timescale 1ns/1ps
`default_nettype none
`include "risl_defines.vh"
module risl_host #(
  parameter logic [7:0] PRIMARY_MODE = 8'h05,
  parameter int         CLK_BIT      = 0,
  parameter int         PLL_BIT      = 1
) (
  input  wire logic        sys_clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata,
  output var  logic        hung
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    hung = 1'b0;
  end
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hready !== 1'b1 && n < 16);
    if (hready !== 1'b1)
      hung = 1'b1;
  endtask
  task automatic xfer(input logic [7:0] i, input logic w, input logic [7:0] d,
                      output logic [31:0] q);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {22'h0, i, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    wait_ready();
    q = hrdata;
  endtask
  // Group 1 any mode, group 2 link mode, group 3 link mode plus clock or PLL
  function automatic logic accept(input int grp, input logic [7:0] raw);
    logic link;
    link = PRIMARY_MODE == 8'h05 || PRIMARY_MODE == 8'h06;
    case (grp)
      1: accept = 1'b1;
      2: accept = link;
      default: accept = link && (raw[CLK_BIT] || raw[PLL_BIT]);
    endcase
  endfunction
  task automatic service(input int grp, output logic [7:0] st);
    logic [31:0] raw;
    logic [31:0] q;
    xfer(`RISL_IDX_LINK_RAW, 1'b0, 8'h00, raw);
    xfer(`RISL_IDX_LINK_ST, 1'b0, 8'h00, q);
    st = q[7:0];
    if (accept(grp, raw[7:0]))
      xfer(`RISL_IDX_LINK_CLR, 1'b1, st, q);
  endtask
endmodule // risl_host
`default_nettype wire

// [tb_risl.sv]
// Self-checking testbench for the interrupt status latch
`timescale 1ns/1ps
`default_nettype none
`include "risl_defines.vh"
module testbench;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hsel, hwrite, hung, hreadyout, hresp, first_irq_output;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic        tv = 1'b0, lk = 1'b0, c1tv = 1'b0, c1lk = 1'b0;
  logic [7:0]  link = 8'h00;
  logic [7:0]  st;
  int          num_errors = 0;
  int          cmp_count = 0;
  always #12.5 sys_clk = ~sys_clk;
  risl_top i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .timing_valid_raw(tv),
    .proc_lock_raw(lk), .ch1_timing_valid_raw(c1tv), .ch1_lock_raw(c1lk),
    .link_event_raw(link), .first_irq_output(first_irq_output));
  risl_host i_host (.sys_clk(sys_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hung(hung));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] i, input logic [31:0] e);
    logic [31:0] q;
    i_host.xfer(i, 1'b0, 8'h00, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [31:0] q;
    i_host.xfer(i, 1'b1, d, q);
  endtask
  // Synchroniser plus edge detect need 3 edges, irq one more
  task automatic settle();
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic step(input logic [7:0] si, input logic [7:0] ev, input logic [3:0] lvl,
                      input logic [7:0] exp);
    wr(`RISL_IDX_EDGE, ev);
    @(posedge sys_clk);
    {c1lk, c1tv, tv, lk} <= lvl;
    settle();
    rd_chk(si, {24'h0, exp});
    chk({31'h0, first_irq_output}, {31'h0, |exp});
    wr(si + 8'h02, 8'hff);
  endtask
  task automatic t_reset();
    rd_chk(`RISL_IDX_OPT, 32'h0);
    rd_chk(`RISL_IDX_EDGE, 32'h30);
    rd_chk(`RISL_IDX_SYNC_ST, 32'h0);
    rd_chk(`RISL_IDX_CH1_ST, 32'h0);
    wr(`RISL_IDX_FORCE_ST, 8'hff);
    rd_chk(`RISL_IDX_FORCE_ST, 32'h0);
    rd_chk(8'h3f, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_force();
    wr(`RISL_IDX_FORCE_SET, 8'h80);
    rd_chk(`RISL_IDX_FORCE_ST, 32'h0);
    wr(`RISL_IDX_FORCE_MASK, 8'h80);
    wr(`RISL_IDX_FORCE_SET, 8'h80);
    rd_chk(`RISL_IDX_FORCE_ST, 32'h80);
    chk({31'h0, first_irq_output}, 32'h1);
    wr(`RISL_IDX_FORCE_CLR, 8'h80);
    rd_chk(`RISL_IDX_FORCE_ST, 32'h0);
    chk({31'h0, first_irq_output}, 32'h0);
    $display("forced test done");
  endtask
  task automatic t_sync();
    wr(`RISL_IDX_SYNC_MASK, 8'h1c);
    wr(`RISL_IDX_CH1_MASK, 8'h0e);
    step(`RISL_IDX_SYNC_ST, 8'h00, 4'b0001, 8'h04);
    step(`RISL_IDX_SYNC_ST, 8'h00, 4'b0000, 8'h08);
    step(`RISL_IDX_SYNC_ST, 8'h00, 4'b0010, 8'h10);
    step(`RISL_IDX_SYNC_ST, 8'h00, 4'b0000, 8'h00);
    step(`RISL_IDX_SYNC_ST, 8'h30, 4'b0011, 8'h1c);
    rd_chk(`RISL_IDX_RAW, 32'h3);
    step(`RISL_IDX_SYNC_ST, 8'h30, 4'b0000, 8'h1c);
    step(`RISL_IDX_CH1_ST, 8'h30, 4'b1000, 8'h08);
    step(`RISL_IDX_CH1_ST, 8'h30, 4'b0000, 8'h04);
    step(`RISL_IDX_CH1_ST, 8'h30, 4'b0100, 8'h02);
    step(`RISL_IDX_CH1_ST, 8'h30, 4'b0000, 8'h02);
    $display("sync test done");
  endtask
  task automatic t_keep();
    @(posedge sys_clk);
    link <= 8'h01;
    settle();
    rd_chk(`RISL_IDX_LINK_ST, 32'h0);
    link <= 8'h00;
    wr(`RISL_IDX_OPT, 8'h10);
    link <= 8'h01;
    settle();
    rd_chk(`RISL_IDX_LINK_ST, 32'h1);
    chk({31'h0, first_irq_output}, 32'h0);
    wr(`RISL_IDX_LINK_MASK, 8'h01);
    rd_chk(`RISL_IDX_LINK_ST, 32'h1);
    chk({31'h0, first_irq_output}, 32'h1);
    i_host.service(3, st);
    chk({24'h0, st}, 32'h1);
    rd_chk(`RISL_IDX_LINK_ST, 32'h0);
    @(posedge sys_clk);
    link <= 8'h04;
    settle();
    i_host.service(3, st);
    chk({24'h0, st}, 32'h4);
    rd_chk(`RISL_IDX_LINK_ST, 32'h4);
    chk({31'h0, first_irq_output}, 32'h0);
    i_host.service(1, st);
    rd_chk(`RISL_IDX_LINK_ST, 32'h0);
    $display("keep test done");
  endtask
  task automatic t_rerun();
    wr(`RISL_IDX_EDGE, 8'h00);
    wr(`RISL_IDX_FORCE_SET, 8'h80);
    rd_chk(`RISL_IDX_FORCE_ST, 32'h80);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd_chk(`RISL_IDX_FORCE_ST, 32'h0);
    rd_chk(`RISL_IDX_FORCE_MASK, 32'h0);
    rd_chk(`RISL_IDX_EDGE, 32'h30);
    rd_chk(`RISL_IDX_LINK_ST, 32'h0);
    chk({31'h0, first_irq_output}, 32'h0);
    $display("mid-run reset test done");
  endtask
  task automatic conclude();
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge hung) begin
    num_errors++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_force();
    t_sync();
    t_keep();
    t_rerun();
    conclude();
  end
endmodule // testbench
`default_nettype wire
